// ===== rtl/sacj_channel.v
// Purpose: one slope converter channel: 16-bit ramp timer and stop flag
// Assumes: tick is a one-cycle enable at the counter rate
// Notes:   the count is held once the threshold trips until cleared
`timescale 1ns/1ps
module sacj_channel (
	// clock and reset
	input  wire        clk,
	input  wire        reset_n,
	// control, already in the tick domain
	input  wire        tick,
	input  wire        count_en,
	input  wire        discharge,
	// comparator
	input  wire        cmp_trip,
	// results
	output reg  [15:0] count_q,
	output reg         stop_q
);

	// counter runs while enabled, not discharging and not stopped
	always @(posedge clk) begin
		if (!reset_n || !count_en) begin
			count_q <= 16'h0000;
			stop_q  <= 1'b0;
		end else if (tick && !discharge) begin
			if (stop_q) begin
				count_q <= count_q;
			end else if (cmp_trip) begin
				stop_q <= 1'b1;
			end else begin
				// wraps after 65536 ticks, as the hardware does
				count_q <= count_q + 16'h0001;
			end
		end
	end

endmodule

// ===== rtl/sacj_consts.vh
// Purpose: constants for the slope converter joystick counters
// Assumes: 20 MHz system clock, 2 MHz counter tick
// Notes:   offsets are byte addresses on the register bus
`ifndef SACJ_CONSTS_VH
`define SACJ_CONSTS_VH

// register byte addresses
`define SACJ_IRQ_CTRL_ADDR   32'h032000e0
`define SACJ_STATUS_ADDR     32'h032000e4
`define SACJ_CONV_CTRL_ADDR  32'h032000e8
`define SACJ_CHANNEL1_COUNT_ADDR       32'h032000ec
`define SACJ_CHANNEL2_COUNT_ADDR       32'h032000f0
`define SACJ_CHANNEL3_COUNT_ADDR       32'h032000f4
`define SACJ_CHANNEL4_COUNT_ADDR       32'h032000f8
`define SACJ_IRQ_STAT_ADDR   32'h032000fc
`define SACJ_IRQ_MASK_ADDR   32'h03200100

// reset values
`define SACJ_IRQ_CTRL_RST    8'h0f
`define SACJ_CONV_CTRL_RST   8'h00
`define SACJ_IRQ_MASK_RST    4'h0

// field positions of the interrupt control register
`define SACJ_IC_ANY_BIT      4
`define SACJ_IC_ALL_BIT      5
`define SACJ_IC_FIRST_BIT    6
`define SACJ_IC_SECOND_BIT   7

// timing: counter tick rate derived from the system clock
`define SACJ_CLK_HZ          20000000
`define SACJ_TICK_HZ         2000000
`define SACJ_TICK_DIV        (`SACJ_CLK_HZ / `SACJ_TICK_HZ)

// bus response codes
`define SACJ_RESP_OKAY       2'h0
`define SACJ_RESP_SLVERR     2'h2

`endif

// ===== rtl/sacj_top.v
// Purpose: four channel slope integration converter with register slave
// Assumes: AXI4-Lite slave, 32-bit data, one clock at 20 MHz
// Notes:   comparator outputs arrive synchronous to clk
//
// Overview of operation
// - Each channel times its ramp with a 16-bit counter that stops at the threshold.
// - A stopped counter sets its stop flag and holds the count until cleared.
// - Per-channel discharge outputs empty the capacitor; release starts a ramp.
// - Each counter is cleared by its own bit among four in converter control.
// - The four counts are read only at 0x032000EC to 0x032000F8; writes do nothing.
// - A channel requests when its stop flag is set and its enable bit is on.
// - Channel requests combine into one interrupt request line.
// - Upper control bits pick any, all-enabled, first pair or second pair combining.
// - Comparator power is the OR of enables; control resets to 0x0F and reads back.
// - Status bits 0 to 3 return the stop flags of channels 1 to 4.
// - Status bits 7 to 4 return stop AND enable; writes ignored; resets to zero.
// - Converter control holds discharge in 7:4 and counter enable in 3:0, reset zero.
// - Counters tick at 2 MHz and wrap after 65536 counts.
`timescale 1ns/1ps
`include "sacj_consts.vh"
module sacj_top (
	// clock and reset
	input  wire        clk,
	input  wire        reset_n,
	// write address channel
	input  wire [31:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	// write data channel
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	// write response channel
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// read address channel
	input  wire [31:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	// read data channel
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// analog side: comparator trips and discharge transistors
	input  wire [3:0]  analog_ramp_pins,
	output reg  [3:0]  discharge_q,
	output reg         cmp_power_q,
	// interrupts
	output reg         interrupt_group_d_q,
	output reg         irq_q
);

	reg  [7:0]  irq_ctrl_q;
	reg  [7:0]  conv_ctrl_q;
	reg  [7:0]  conv_sync_q;
	reg  [3:0]  irq_stat_q;
	reg  [3:0]  irq_mask_q;
	reg  [3:0]  stop_prev_q;
	reg  [3:0]  div_q;
	reg         tick_q;
	reg  [31:0] awaddr_q;
	reg  [31:0] wdata_q;
	reg  [3:0]  wstrb_q;
	reg         aw_have_q;
	reg         w_have_q;
	wire [63:0] counts;
	wire [3:0]  stops;
	wire [3:0]  chan_req;
	wire [3:0]  enables;
	wire        any_req;
	wire        all_req;
	wire        combined;
	wire        do_write;
	wire        stat_rd;
	wire [3:0]  stop_rise;
	reg  [31:0] rd_data;
	reg  [1:0]  rd_resp;

	// one-cycle tick every tenth clock gives the 2 MHz counter rate
	always @(posedge clk) begin
		if (!reset_n) begin
			div_q  <= 4'h0;
			tick_q <= 1'b0;
		end else if (div_q == (`SACJ_TICK_DIV - 1)) begin
			div_q  <= 4'h0;
			tick_q <= 1'b1;
		end else begin
			div_q  <= div_q + 4'h1;
			tick_q <= 1'b0;
		end
	end

	// control is handed to the counters only on a tick, so a half
	// written setting never reaches a counter mid-period
	always @(posedge clk) begin
		if (!reset_n) begin
			conv_sync_q <= `SACJ_CONV_CTRL_RST;
			discharge_q <= 4'h0;
		end else if (tick_q) begin
			conv_sync_q <= conv_ctrl_q;
			discharge_q <= conv_ctrl_q[7:4];
		end
	end

	// one channel instance per comparator
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : chan
			sacj_channel u_chan (
				.clk       (clk),
				.reset_n   (reset_n),
				.tick      (tick_q),
				.count_en  (conv_sync_q[g]),
				.discharge (conv_sync_q[g+4]),
				.cmp_trip  (analog_ramp_pins[g]),
				.count_q   (counts[g*16 +: 16]),
				.stop_q    (stops[g])
			);
		end
	endgenerate

	// per-channel requests and the combining rule
	assign enables  = irq_ctrl_q[3:0];
	assign chan_req = stops & enables;
	assign any_req  = |chan_req;
	assign all_req  = (enables != 4'h0) && (chan_req == enables);
	assign combined =
		(irq_ctrl_q[`SACJ_IC_ANY_BIT]    && any_req) ||
		(irq_ctrl_q[`SACJ_IC_ALL_BIT]    && all_req) ||
		(irq_ctrl_q[`SACJ_IC_FIRST_BIT]  && (|chan_req[1:0])) ||
		(irq_ctrl_q[`SACJ_IC_SECOND_BIT] && (|chan_req[3:2]));

	// single request line and comparator power
	always @(posedge clk) begin
		if (!reset_n) begin
			interrupt_group_d_q <= 1'b0;
			cmp_power_q         <= 1'b1;
		end else begin
			interrupt_group_d_q <= combined;
			cmp_power_q         <= |enables;
		end
	end

	// write path: address and data may arrive in either order
	assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;

	always @(posedge clk) begin
		if (!reset_n) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `SACJ_RESP_OKAY;
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			awaddr_q      <= 32'h00000000;
			wdata_q       <= 32'h00000000;
			wstrb_q       <= 4'h0;
			irq_ctrl_q    <= `SACJ_IRQ_CTRL_RST;
			conv_ctrl_q   <= `SACJ_CONV_CTRL_RST;
			irq_mask_q    <= `SACJ_IRQ_MASK_RST;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_q      <= s_axi_awaddr;
				aw_have_q     <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_q      <= s_axi_wdata;
				wstrb_q      <= s_axi_wstrb;
				w_have_q     <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= `SACJ_RESP_OKAY;
				if (!wstrb_q[0]) begin
					s_axi_bresp <= `SACJ_RESP_OKAY;
				end else if (awaddr_q == `SACJ_IRQ_CTRL_ADDR) begin
					irq_ctrl_q <= wdata_q[7:0];
				end else if (awaddr_q == `SACJ_CONV_CTRL_ADDR) begin
					conv_ctrl_q <= wdata_q[7:0];
				end else if (awaddr_q == `SACJ_IRQ_MASK_ADDR) begin
					irq_mask_q <= wdata_q[3:0];
				end else if ((awaddr_q == `SACJ_STATUS_ADDR) ||
				             (awaddr_q == `SACJ_IRQ_STAT_ADDR) ||
				             (awaddr_q >= `SACJ_CHANNEL1_COUNT_ADDR &&
				              awaddr_q <= `SACJ_CHANNEL4_COUNT_ADDR &&
				              awaddr_q[1:0] == 2'h0)) begin
					s_axi_bresp <= `SACJ_RESP_OKAY;
				end else begin
					s_axi_bresp <= `SACJ_RESP_SLVERR;
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// read decode
	always @* begin
		rd_data = 32'h00000000;
		rd_resp = `SACJ_RESP_OKAY;
		if (s_axi_araddr == `SACJ_IRQ_CTRL_ADDR) begin
			rd_data = {24'h000000, irq_ctrl_q};
		end else if (s_axi_araddr == `SACJ_STATUS_ADDR) begin
			rd_data = {24'h000000, chan_req, stops};
		end else if (s_axi_araddr == `SACJ_CONV_CTRL_ADDR) begin
			rd_data = {24'h000000, conv_ctrl_q};
		end else if (s_axi_araddr == `SACJ_CHANNEL1_COUNT_ADDR) begin
			rd_data = {16'h0000, counts[15:0]};
		end else if (s_axi_araddr == `SACJ_CHANNEL2_COUNT_ADDR) begin
			rd_data = {16'h0000, counts[31:16]};
		end else if (s_axi_araddr == `SACJ_CHANNEL3_COUNT_ADDR) begin
			rd_data = {16'h0000, counts[47:32]};
		end else if (s_axi_araddr == `SACJ_CHANNEL4_COUNT_ADDR) begin
			rd_data = {16'h0000, counts[63:48]};
		end else if (s_axi_araddr == `SACJ_IRQ_STAT_ADDR) begin
			rd_data = {28'h0000000, irq_stat_q};
		end else if (s_axi_araddr == `SACJ_IRQ_MASK_ADDR) begin
			rd_data = {28'h0000000, irq_mask_q};
		end else begin
			rd_resp = `SACJ_RESP_SLVERR;
		end
	end

	// read path: address taken when no read is pending
	assign stat_rd = s_axi_arvalid && s_axi_arready &&
	                 (s_axi_araddr == `SACJ_IRQ_STAT_ADDR);

	always @(posedge clk) begin
		if (!reset_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `SACJ_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_data;
			s_axi_rresp   <= rd_resp;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// sticky stop events, cleared by reading them; a new event wins
	assign stop_rise = stops & ~stop_prev_q;

	always @(posedge clk) begin
		if (!reset_n) begin
			stop_prev_q <= 4'h0;
			irq_stat_q  <= 4'h0;
			irq_q       <= 1'b0;
		end else begin
			stop_prev_q <= stops;
			irq_stat_q  <= (stat_rd ? 4'h0 : irq_stat_q) | stop_rise;
			irq_q       <= |(irq_stat_q & irq_mask_q);
		end
	end

endmodule

// ===== tb/sacj_props.sv
// Purpose: port checks on the converter top
// Assumes: one clock, synchronous active-low reset
// Notes:   outputs leave reset state only after a write
`timescale 1ns/1ps
module sacj_props (
	// clock and reset
	input wire        clk,
	input wire        reset_n,
	// register bus
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire        s_axi_bvalid,
	input wire [31:0] s_axi_araddr,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0]  s_axi_rresp,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	// device outputs
	input wire [3:0]  discharge_q,
	input wire        interrupt_group_d_q,
	input wire        irq_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic wr_seen_q;
	// set at the address handshake, so it leads any register update
	always @(posedge clk)
		if (!reset_n) wr_seen_q <= 1'b0;
		else if (s_axi_awvalid && s_axi_awready) wr_seen_q <= 1'b1;
	sequence ar_hs;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence wr_hs;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	AST_RD_SLOT: assert property (ar_hs |=> s_axi_rvalid)
		else $error("read answer late");
	AST_WR_SLOT: assert property (wr_hs |-> ##[1:2] s_axi_bvalid)
		else $error("write answer late");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
	AST_UNMAPPED: assert property (
		s_axi_arvalid && s_axi_arready &&
		!(s_axi_araddr inside {[32'h032000e0:32'h03200100]}) |=>
		s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	AST_STAT_W: assert property (
		s_axi_arvalid && s_axi_arready &&
		s_axi_araddr == 32'h032000e4 |=> s_axi_rdata[31:8] == 24'h0)
		else $error("status upper bits set");
	AST_CNT_W: assert property (
		s_axi_arvalid && s_axi_arready &&
		s_axi_araddr inside {[32'h032000ec:32'h032000f8]} |=>
		s_axi_rdata[31:16] == 16'h0 && s_axi_rresp == 2'h0)
		else $error("count read wider than 16 bits");
	AST_DIS_RST: assert property (discharge_q != 4'h0 |-> wr_seen_q)
		else $error("discharge without write");
	AST_GRP_RST: assert property (interrupt_group_d_q |-> wr_seen_q)
		else $error("combined request from reset state");
	AST_IRQ_RST: assert property (irq_q |-> wr_seen_q)
		else $error("interrupt with reset mask");
endmodule
bind sacj_top sacj_props u_props (.*);

// ===== tb/sacj_rc_model.sv
// Purpose: external rc ramps and comparators, four channels
// Assumes: ramp lengths counted in system clocks
// Notes:   ramps saturate, so a stopped channel keeps tripping
`timescale 1ns/1ps
module sacj_rc_model (
	// clock
	input  wire        clk,
	// from the converter
	input  wire [3:0]  discharge_q,
	input  wire        cmp_power_q,
	// ramp lengths, channel 1 lowest
	input  wire [63:0] ramp_len,
	// comparator outputs
	output logic [3:0] trip
);
	logic [15:0] v [4];
	initial foreach (v[k]) v[k] = 16'h0000;
	// discharge empties the capacitor, release restarts it
	always @(posedge clk)
		foreach (v[k])
			if (discharge_q[k]) v[k] <= 16'h0000;
			else if (v[k] != 16'hffff) v[k] <= v[k] + 16'h0001;
	// unpowered comparators never trip
	always_comb
		foreach (v[k])
			trip[k] = cmp_power_q && v[k] >= ramp_len[16*k +: 16];
endmodule

// ===== tb/tb_top.sv
// Purpose: register-level tests of the converter top
// Assumes: one access at a time, inputs moved on rising edges
// Notes:   counts checked in a window, tick phase is not fixed
`timescale 1ns/1ps
`include "sacj_consts.vh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
	error_cnt++; $display("FAIL t=%0t got %h exp %h", $time, a, b); end end
module tb_top;
	logic clk, reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_rready;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, rdv;
	logic [3:0] s_axi_wstrb;
	logic [1:0] rsp;
	logic [15:0] c1;
	wire [3:0] analog_ramp_pins, discharge_q;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire s_axi_rvalid, cmp_power_q, interrupt_group_d_q, irq_q;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	int error_cnt, n_compared, i;
	// {combined request expected, interrupt control}
	logic [8:0] tbl [8] = '{9'h11f, 9'h12f, 9'h121, 9'h044,
		9'h142, 9'h081, 9'h188, 9'h0f0};
	sacj_top DUT (.*);
	sacj_rc_model u_rc (.clk(clk), .discharge_q(discharge_q),
		.cmp_power_q(cmp_power_q), .ramp_len(64'h0320_0258_0190_00c8),
		.trip(analog_ramp_pins));
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// both write channels offered at once, each dropped when taken;
	// bready stays up between writes so it is never toggled in one step
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic ah, wh;
		ah = 1'b0;
		wh = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ah && wh)) begin
			@(posedge clk);
			ah = ah | s_axi_awready;
			wh = wh | s_axi_wready;
			if (ah) s_axi_awvalid <= 1'b0;
			if (wh) s_axi_wvalid <= 1'b0;
		end
		do @(posedge clk); while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
	endtask
	// hold > 0 keeps rready low for that many edges, so the read
	// answer must stand; rready is otherwise left up between reads
	task automatic rd(input logic [31:0] a, input int hold = 0);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= (hold == 0);
		do @(posedge clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		if (hold > 0) begin
			repeat (hold) @(posedge clk);
			s_axi_rready <= 1'b1;
		end
		do @(posedge clk); while (s_axi_rvalid !== 1'b1);
		rdv = s_axi_rdata;
		rsp = s_axi_rresp;
	endtask
	task automatic test_done;
		$display("compared %0d, mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		{reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid,
			s_axi_rready, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		s_axi_wstrb = 4'hf;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		rd(`SACJ_IRQ_CTRL_ADDR);
		`CHK(rdv, 32'h0000000f)
		rd(`SACJ_CONV_CTRL_ADDR);
		`CHK(rdv, 32'h00000000)
		rd(`SACJ_STATUS_ADDR);
		`CHK(rdv, 32'h00000000)
		`CHK(cmp_power_q, 1'b1)
		rd(32'h03200200);
		`CHK(rsp, `SACJ_RESP_SLVERR)
		wr(32'h03200200, 32'h00000000);
		`CHK(rsp, `SACJ_RESP_SLVERR)
		// a write with the low byte lane off leaves control alone
		s_axi_wstrb <= 4'h0;
		wr(`SACJ_IRQ_CTRL_ADDR, 32'h000000ff);
		s_axi_wstrb <= 4'hf;
		`CHK(rsp, `SACJ_RESP_OKAY)
		rd(`SACJ_IRQ_CTRL_ADDR);
		`CHK(rdv, 32'h0000000f)
		// discharge with counters cleared, then release all four
		wr(`SACJ_CONV_CTRL_ADDR, 32'h000000f0);
		repeat (30) @(posedge clk);
		`CHK(discharge_q, 4'hf)
		wr(`SACJ_CONV_CTRL_ADDR, 32'h0000000f);
		repeat (30) @(posedge clk);
		`CHK(discharge_q, 4'h0)
		do rd(`SACJ_STATUS_ADDR); while (rdv[3:0] !== 4'hf);
		`CHK(rdv, 32'h000000ff)
		for (i = 0; i < 4; i++) begin
			rd(`SACJ_CHANNEL1_COUNT_ADDR + 4 * i);
			`CHK(rdv >= 18 + 20 * i && rdv <= 22 + 20 * i, 1'b1)
		end
		// read-only places ignore writes and the count holds
		rd(`SACJ_CHANNEL1_COUNT_ADDR);
		c1 = rdv[15:0];
		wr(`SACJ_CHANNEL1_COUNT_ADDR, 32'h00000000);
		`CHK(rsp, `SACJ_RESP_OKAY)
		wr(`SACJ_STATUS_ADDR, 32'h00000000);
		repeat (200) @(posedge clk);
		rd(`SACJ_CHANNEL1_COUNT_ADDR);
		`CHK(rdv, {16'h0000, c1})
		rd(`SACJ_STATUS_ADDR);
		`CHK(rdv, 32'h000000ff)
		// stop events are sticky, masked until enabled, read clears
		`CHK(irq_q, 1'b0)
		wr(`SACJ_IRQ_MASK_ADDR, 32'h0000000f);
		repeat (2) @(posedge clk);
		`CHK(irq_q, 1'b1)
		rd(`SACJ_IRQ_STAT_ADDR);
		`CHK(rdv, 32'h0000000f)
		repeat (3) @(posedge clk);
		`CHK(irq_q, 1'b0)
		// every combining mode, with enables that pass and block
		for (i = 0; i < 8; i++) begin
			wr(`SACJ_IRQ_CTRL_ADDR, {24'h0, tbl[i][7:0]});
			repeat (3) @(posedge clk);
			`CHK(interrupt_group_d_q, tbl[i][8])
			`CHK(cmp_power_q, |tbl[i][3:0])
			rd(`SACJ_IRQ_CTRL_ADDR);
			`CHK(rdv, {24'h0, tbl[i][7:0]})
			rd(`SACJ_STATUS_ADDR);
			`CHK(rdv[7:4], tbl[i][3:0])
		end
		// clear channel 1 alone; all-enabled mode must then drop
		wr(`SACJ_IRQ_CTRL_ADDR, 32'h0000002f);
		wr(`SACJ_CONV_CTRL_ADDR, 32'h0000000e);
		repeat (30) @(posedge clk);
		`CHK(interrupt_group_d_q, 1'b0)
		rd(`SACJ_CHANNEL1_COUNT_ADDR);
		`CHK(rdv, 32'h00000000)
		rd(`SACJ_CHANNEL2_COUNT_ADDR, 2);
		`CHK(rdv >= 38 && rdv <= 42, 1'b1)
		rd(`SACJ_STATUS_ADDR);
		`CHK(rdv, 32'h000000ee)
		test_done;
	end
	// the run needs well under two thousand cycles; this cuts a hang short
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		test_done;
	end
endmodule
